// ---- sdmr_ctrl_model.sv ----
module sdmr_ctrl_model (
  input wire logic i_clk,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [sdmr_pkg::BANK_W-1:0] o_bank_sel,
  output logic [sdmr_pkg::ADDR_W-1:0] o_addr,
  output logic o_odt,
  output logic o_bank_open
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock above limit
  // The clock stays at 40 MHz, so refreshes need no trailing precharge-all.
  initial begin
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = 5'h1f;
    o_bank_sel = '0;
    o_addr = '0;
    o_odt = 1'b0;
    o_bank_open = 1'b0;
  end
  // Address and bank lines show the inverted word once the command is gone.
  task automatic issue(input logic [3:0] cmd, input logic [2:0] bank, input logic [12:0] addr, input logic cke);
    @(posedge i_clk);
    #2;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
    o_bank_sel = bank;
    o_addr = addr;
    o_cke = cke;
    @(posedge i_clk);
    #2;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_addr = ~addr;
    o_bank_sel = ~bank;
  endtask : issue
  // idle load
  // Loads come only with all banks idle, bank bit 2 low, select 00 or 01 taken from sel.
  task automatic load(input logic [1:0] sel, input logic [12:0] word);
    issue(4'h0, {1'b0, sel}, word, 1'b1);
  endtask : load
  // termination held low
  // The bench keeps termination low around self refresh and before enabling it.
  task automatic set_pins(input logic cke, input logic odt, input logic bank_open);
    @(posedge i_clk);
    #2;
    o_cke = cke;
    o_odt = odt;
    o_bank_open = bank_open;
  endtask : set_pins
endmodule : sdmr_ctrl_model

// ---- sdmr_delay_line.sv ----
module sdmr_delay_line #(
  parameter int unsigned DEPTH = sdmr_pkg::DLY_DEPTH,
  parameter int unsigned SEL_W = sdmr_pkg::DLY_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pulse,
  input wire logic [SEL_W-1:0] i_delay,
  output logic o_pulse
);
  typedef struct packed {
    logic [DEPTH-1:0] taps;
  } sdmr_dly_state_type;

  sdmr_dly_state_type st_q;
  sdmr_dly_state_type st_d;

  // A pulse enters at the tap from which it reaches the last one i_delay edges later.
  always_comb begin
    st_d.taps = {st_q.taps[DEPTH-2:0], 1'b0};
    for (int k = 0; k < DEPTH; k++) begin
      if (i_pulse && (i_delay != '0) && (k == int'(DEPTH - 1) - int'(i_delay))) begin
        st_d.taps[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_pulse = st_q.taps[DEPTH-1];
endmodule : sdmr_delay_line

// ---- sdmr_mode_decode.sv ----
// What this block does
// RULE1: Test-mode bit set stores nothing else and enters test mode; controller never sets it (the bench sets it once, loading 13'h02f2).
// RULE2: DLL-restart bit starts a DLL reset and clears itself afterwards.
// RULE3: Controller waits 200 clocks after any DLL reset before a READ.
// RULE4: Write with auto precharge starts precharge write-recovery clocks after last data.
// RULE5: Controller programs write recovery 2 to 8, rounded up, no reserved codes.
// RULE6: Exit-style bit picks fast or slow active power-down exit; slow may freeze DLL.
// RULE7: Read-latency field gives 3 to 7 clocks; data at edge n plus latency.
// RULE8: Controller never programs reserved read-latency codes.
// RULE9: Controller loads extended settings only when idle, then waits the set delay.
// RULE10: Extended settings hold until reloaded; reloading leaves the array untouched.
// RULE11: Controller enables DLL at init and follows each enable with a DLL reset.
// RULE12: Self refresh entry disables the DLL; exit re-enables and resets it.
// RULE13: With DLL off below 25 MHz, controller follows refresh with precharge all.
// RULE14: Drive-strength bit zero is full drive, one is reduced drive.
// RULE15: Strobe-complement bit disables complement strobe and complement read strobe.
// RULE16: Read-strobe bit copies data strobe on reads on byte-wide parts only.
// RULE17: Output-disable bit turns off all data and strobe outputs.
// RULE18: Two termination bits select 50, 75 or 150 ohm or off.
// RULE19: Termination acts only in active and power-down states, never in self refresh.
// RULE20: Controller holds termination input low eight clocks after enabling termination.
// RULE21: Controller sets driver-calibration bits to ones, then zeros, during initialization.
// RULE22: Controller programs bits above address 12 and third bank bit to zero.
// RULE23: Additive-latency field 0 to 6 delays each READ or WRITE internally.
// RULE24: Read latency is additive plus read-latency setting; write latency one less.
// RULE25: Controller selects extended settings with bank bit 0 high, bit 1 low.
// RULE26: Low three bits select burst length four or eight.
// RULE27: Settings are captured on the LOAD MODE edge and are never readable.
module sdmr_mode_decode #(
  parameter int unsigned ADDR_W = sdmr_pkg::ADDR_W,
  parameter int unsigned BANK_W = sdmr_pkg::BANK_W,
  parameter bit BYTE_WIDE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [BANK_W-1:0] i_bank_sel,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_odt,
  input wire logic i_bank_open,
  output logic o_test_mode,
  output logic o_dll_enabled,
  output logic o_dll_reset,
  output logic o_dll_locked,
  output logic o_self_refresh,
  output logic o_burst_len8,
  output logic [sdmr_pkg::LAT_W-1:0] o_read_latency,
  output logic [sdmr_pkg::LAT_W-1:0] o_write_latency,
  output logic [sdmr_pkg::LAT_W-1:0] o_write_recovery,
  output logic o_pd_slow_exit,
  output logic o_dll_frozen,
  output logic o_reduced_drive,
  output logic [1:0] o_termination_sel,
  output logic o_term_active,
  output logic o_driver_cal_default,
  output logic o_dq_out_en,
  output logic o_dqs_n_en,
  output logic o_rdqs_en,
  output logic o_rdqs_n_en,
  output logic o_read_issue,
  output logic o_read_data_start,
  output logic o_write_data_start,
  output logic o_precharge_start
);
  localparam int unsigned LW = sdmr_pkg::LAT_W;
  localparam int unsigned DW = sdmr_pkg::DLY_W;
  localparam int unsigned KW = sdmr_pkg::LOCK_W;

  typedef struct packed {
    logic [ADDR_W-1:0] op;
    logic [ADDR_W-1:0] ext;
    logic test_mode;
    sdmr_pkg::sdmr_pwr_type pwr;
    logic sref;
    logic dll_on;
    logic dll_rst;
    logic [sdmr_pkg::LOCK_W-1:0] lock_cnt;
    logic locked;
    logic bl8;
    logic [LW-1:0] rl;
    logic [LW-1:0] wl;
    logic [LW-1:0] wr;
    logic frozen;
    logic term;
    logic cal_def;
    logic dq_en;
    logic dqs_n_en;
    logic rdqs_en;
    logic rdqs_n_en;
  } sdmr_state_type;

  sdmr_state_type st_q;
  sdmr_state_type st_d;
  logic cmd_load;
  logic cmd_read;
  logic cmd_write;
  logic cmd_refresh;
  logic load_op;
  logic load_ext;
  logic wr_auto_pre;
  logic [DW-1:0] issue_dly;
  logic [DW-1:0] rl_dly;
  logic [DW-1:0] wl_dly;
  logic [DW-1:0] pre_dly;

  assign cmd_load = !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
  assign cmd_read = !i_cs_n && i_ras_n && !i_cas_n && i_we_n;
  assign cmd_write = !i_cs_n && i_ras_n && !i_cas_n && !i_we_n;
  assign cmd_refresh = !i_cs_n && !i_ras_n && !i_cas_n && i_we_n;
  // The third bank bit is expected at zero and is not decoded.
  assign load_op = cmd_load && (i_bank_sel[1:0] == sdmr_pkg::SEL_OPERATING);
  assign load_ext = cmd_load && (i_bank_sel[1:0] == sdmr_pkg::SEL_EXTENDED);
  assign wr_auto_pre = cmd_write && i_addr[sdmr_pkg::AUTO_PRECHARGE_BIT];

  always_comb begin
    st_d = st_q;
    st_d.dll_rst = 1'b0;
    // RULE27 capture on load
    if (load_op) begin
      // RULE1 test mode gate
      st_d.test_mode = i_addr[sdmr_pkg::TEST_MODE_SELECT_BIT];
      if (!i_addr[sdmr_pkg::TEST_MODE_SELECT_BIT]) begin
        st_d.op = i_addr;
        // RULE2 self-clearing restart
        st_d.op[sdmr_pkg::DLL_RESTART_BIT] = 1'b0;
        st_d.dll_rst = i_addr[sdmr_pkg::DLL_RESTART_BIT];
      end
    end
    // RULE10 hold until reload
    if (load_ext) begin
      st_d.ext = i_addr;
    end
    case (st_q.pwr)
      sdmr_pkg::PWR_ACTIVE: begin
        if (cmd_refresh && !i_cke) begin
          st_d.pwr = sdmr_pkg::PWR_SELF_REFRESH;
        end else if (!i_cke) begin
          st_d.pwr = sdmr_pkg::PWR_POWER_DOWN;
        end
      end
      sdmr_pkg::PWR_POWER_DOWN: begin
        if (i_cke) begin
          st_d.pwr = sdmr_pkg::PWR_ACTIVE;
        end
      end
      sdmr_pkg::PWR_SELF_REFRESH: begin
        if (i_cke) begin
          st_d.pwr = sdmr_pkg::PWR_ACTIVE;
          // RULE12 reset on exit
          st_d.dll_rst = 1'b1;
        end
      end
      default: begin
        st_d.pwr = sdmr_pkg::PWR_ACTIVE;
      end
    endcase
    // RULE12 off in self refresh
    st_d.dll_on = !st_d.ext[sdmr_pkg::DLL_DISABLE_BIT] && (st_d.pwr != sdmr_pkg::PWR_SELF_REFRESH);
    st_d.sref = (st_d.pwr == sdmr_pkg::PWR_SELF_REFRESH);
    // Lock status counts clocks since the last DLL reset or DLL enable.
    if (st_d.dll_rst || !st_d.dll_on) begin
      st_d.lock_cnt = '0;
      st_d.locked = 1'b0;
    end else if (!st_q.locked) begin
      st_d.lock_cnt = st_q.lock_cnt + KW'(1'b1);
      st_d.locked = (st_d.lock_cnt == KW'(sdmr_pkg::DLL_LOCK_CLOCKS));
    end
    // RULE26 burst length
    st_d.bl8 = (st_d.op[sdmr_pkg::BURST_LENGTH_LSB +: sdmr_pkg::FIELD_W] == sdmr_pkg::BURST_CODE_8);
    // RULE24 latency sums
    st_d.rl = LW'(st_d.op[sdmr_pkg::READ_LATENCY_LSB +: sdmr_pkg::FIELD_W])
            + LW'(st_d.ext[sdmr_pkg::ADDITIVE_LATENCY_LSB +: sdmr_pkg::FIELD_W]);
    st_d.wl = st_d.rl - sdmr_pkg::LAT_ONE;
    st_d.wr = LW'(st_d.op[sdmr_pkg::WRITE_RECOVERY_LSB +: sdmr_pkg::FIELD_W]) + sdmr_pkg::LAT_ONE;
    // RULE6 slow exit freezes DLL
    st_d.frozen = st_d.op[sdmr_pkg::POWERDOWN_EXIT_STYLE_BIT] && i_bank_open
                && (st_d.pwr == sdmr_pkg::PWR_POWER_DOWN);
    // RULE19 termination state gate
    st_d.term = i_odt && (st_d.pwr != sdmr_pkg::PWR_SELF_REFRESH)
              && ({st_d.ext[sdmr_pkg::TERMINATION_SELECT_HIGH], st_d.ext[sdmr_pkg::TERMINATION_SELECT_LOW]}
                  != sdmr_pkg::TERM_OFF);
    st_d.cal_def = (st_d.ext[sdmr_pkg::DRIVER_CALIBRATION_LSB +: sdmr_pkg::FIELD_W]
                    == sdmr_pkg::DRIVER_CALIBRATION_DEFAULT);
    // RULE17 output disable
    st_d.dq_en = !st_d.ext[sdmr_pkg::OUTPUT_DISABLE_BIT];
    // RULE15 complement strobe
    st_d.dqs_n_en = st_d.dq_en && !st_d.ext[sdmr_pkg::STROBE_COMPLEMENT_DISABLE_BIT];
    // RULE16 read strobe on byte-wide
    st_d.rdqs_en = BYTE_WIDE && st_d.dq_en && st_d.ext[sdmr_pkg::READ_STROBE_ENABLE_BIT];
    st_d.rdqs_n_en = st_d.rdqs_en && st_d.dqs_n_en;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // RULE23 additive hold
  assign issue_dly = DW'(st_q.ext[sdmr_pkg::ADDITIVE_LATENCY_LSB +: sdmr_pkg::FIELD_W]) + DW'(sdmr_pkg::LAT_ONE);
  // RULE7 read data timing
  assign rl_dly = DW'(st_q.rl);
  assign wl_dly = DW'(st_q.wl);
  // RULE4 write recovery delay
  assign pre_dly = DW'(st_q.wl) + DW'(st_q.bl8 ? sdmr_pkg::HALF_BURST_8 : sdmr_pkg::HALF_BURST_4) + DW'(st_q.wr);

  sdmr_delay_line u_issue (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pulse(cmd_read), .i_delay(issue_dly),
                           .o_pulse(o_read_issue));
  sdmr_delay_line u_rdata (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pulse(cmd_read), .i_delay(rl_dly),
                           .o_pulse(o_read_data_start));
  sdmr_delay_line u_wdata (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pulse(cmd_write), .i_delay(wl_dly),
                           .o_pulse(o_write_data_start));
  sdmr_delay_line u_pre (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pulse(wr_auto_pre), .i_delay(pre_dly),
                         .o_pulse(o_precharge_start));

  assign o_test_mode = st_q.test_mode;
  assign o_dll_enabled = st_q.dll_on;
  assign o_dll_reset = st_q.dll_rst;
  assign o_dll_locked = st_q.locked;
  assign o_self_refresh = st_q.sref;
  assign o_burst_len8 = st_q.bl8;
  assign o_read_latency = st_q.rl;
  assign o_write_latency = st_q.wl;
  assign o_write_recovery = st_q.wr;
  assign o_pd_slow_exit = st_q.op[sdmr_pkg::POWERDOWN_EXIT_STYLE_BIT];
  assign o_dll_frozen = st_q.frozen;
  // RULE14 drive strength
  assign o_reduced_drive = st_q.ext[sdmr_pkg::DRIVE_STRENGTH_BIT];
  // RULE18 termination select
  assign o_termination_sel = {st_q.ext[sdmr_pkg::TERMINATION_SELECT_HIGH], st_q.ext[sdmr_pkg::TERMINATION_SELECT_LOW]};
  assign o_term_active = st_q.term;
  assign o_driver_cal_default = st_q.cal_def;
  assign o_dq_out_en = st_q.dq_en;
  assign o_dqs_n_en = st_q.dqs_n_en;
  assign o_rdqs_en = st_q.rdqs_en;
  assign o_rdqs_n_en = st_q.rdqs_n_en;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_test_mode_blocks;
    (load_op && i_addr[sdmr_pkg::TEST_MODE_SELECT_BIT]) |=> (o_test_mode && $stable(st_q.op));
  endproperty
  a_test_mode_blocks: assert property (p_test_mode_blocks) else $error("test mode load changed settings"); // RULE1
  property p_dll_restart;
    (load_op && i_addr[sdmr_pkg::DLL_RESTART_BIT] && !i_addr[sdmr_pkg::TEST_MODE_SELECT_BIT])
      |=> o_dll_reset ##1 (!o_dll_reset || $past(cmd_load));
  endproperty
  a_dll_restart: assert property (p_dll_restart) else $error("dll reset not a single pulse"); // RULE2
  property p_precharge;
    (wr_auto_pre && (o_write_latency == 4'h2) && !o_burst_len8 && (o_write_recovery == 4'h2))
      |-> ##7 o_precharge_start;
  endproperty
  a_precharge: assert property (p_precharge) else $error("auto precharge late or missing"); // RULE4
  property p_slow_freeze;
    o_dll_frozen |-> (o_pd_slow_exit && !o_self_refresh);
  endproperty
  a_slow_freeze: assert property (p_slow_freeze) else $error("dll frozen outside slow exit"); // RULE6
  property p_read_data;
    (cmd_read && (o_read_latency == 4'h3)) |-> ##4 o_read_data_start;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not at latency"); // RULE7
  property p_ext_hold;
    !load_ext |=> $stable(st_q.ext);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended settings changed without load"); // RULE10
  property p_self_refresh_dll;
    (o_self_refresh && i_cke) |=> (o_dll_reset && !o_dll_locked && !o_self_refresh);
  endproperty
  a_self_refresh_dll: assert property (p_self_refresh_dll) else $error("dll not reset on exit"); // RULE12
  property p_drive;
    load_ext |=> (o_reduced_drive == $past(i_addr[sdmr_pkg::DRIVE_STRENGTH_BIT]));
  endproperty
  a_drive: assert property (p_drive) else $error("drive strength not captured"); // RULE14
  property p_complement;
    (load_ext && i_addr[sdmr_pkg::STROBE_COMPLEMENT_DISABLE_BIT]) |=> !(o_dqs_n_en || o_rdqs_n_en);
  endproperty
  a_complement: assert property (p_complement) else $error("complement strobes on while disabled"); // RULE15
  property p_out_off;
    (load_ext && i_addr[sdmr_pkg::OUTPUT_DISABLE_BIT]) |=> !(o_dq_out_en || o_dqs_n_en || o_rdqs_en);
  endproperty
  a_out_off: assert property (p_out_off) else $error("outputs on while disabled"); // RULE17
  property p_term_sr;
    o_self_refresh |-> !o_term_active;
  endproperty
  a_term_sr: assert property (p_term_sr) else $error("termination active in self refresh"); // RULE19
  property p_latency;
    (o_read_latency != 4'h0) |-> (o_write_latency == o_read_latency - 4'h1);
  endproperty
  a_latency: assert property (p_latency) else $error("write latency not read latency less one"); // RULE24

  c_read: cover property (cmd_read ##2 o_read_issue);
  c_precharge: cover property (wr_auto_pre ##[1:30] o_precharge_start);
  c_self_refresh: cover property (o_self_refresh ##[1:20] o_dll_reset);
  c_term: cover property (o_term_active);
endmodule : sdmr_mode_decode

// ---- sdmr_pkg.sv ----
package sdmr_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned LAT_W = 4;
  localparam int unsigned DLY_W = 5;
  localparam int unsigned DLY_DEPTH = 32;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned LOCK_W = 8;
  localparam int unsigned DLL_LOCK_CLOCKS = 200;
  localparam int unsigned BURST_LENGTH_LSB = 0;
  localparam int unsigned READ_LATENCY_LSB = 4;
  localparam int unsigned TEST_MODE_SELECT_BIT = 7;
  localparam int unsigned DLL_RESTART_BIT = 8;
  localparam int unsigned WRITE_RECOVERY_LSB = 9;
  localparam int unsigned POWERDOWN_EXIT_STYLE_BIT = 12;
  localparam int unsigned DLL_DISABLE_BIT = 0;
  localparam int unsigned DRIVE_STRENGTH_BIT = 1;
  localparam int unsigned TERMINATION_SELECT_LOW = 2;
  localparam int unsigned ADDITIVE_LATENCY_LSB = 3;
  localparam int unsigned TERMINATION_SELECT_HIGH = 6;
  localparam int unsigned DRIVER_CALIBRATION_LSB = 7;
  localparam int unsigned STROBE_COMPLEMENT_DISABLE_BIT = 10;
  localparam int unsigned READ_STROBE_ENABLE_BIT = 11;
  localparam int unsigned OUTPUT_DISABLE_BIT = 12;
  localparam int unsigned AUTO_PRECHARGE_BIT = 10;
  localparam logic [1:0] SEL_OPERATING = 2'h0;
  localparam logic [1:0] SEL_EXTENDED = 2'h1;
  localparam logic [1:0] TERM_OFF = 2'h0;
  localparam logic [2:0] BURST_CODE_8 = 3'h3;
  localparam logic [2:0] DRIVER_CALIBRATION_DEFAULT = 3'h7;
  localparam logic [3:0] HALF_BURST_4 = 4'h2;
  localparam logic [3:0] HALF_BURST_8 = 4'h4;
  localparam logic [3:0] LAT_ONE = 4'h1;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_POWER_DOWN = 2'b01,
    PWR_SELF_REFRESH = 2'b10
  } sdmr_pwr_type;
endpackage : sdmr_pkg

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, odt, bank_open;
  logic [2:0] bank_sel;
  logic [12:0] addr;
  logic test_mode, dll_en, dll_rst, dll_lock, sref, bl8, pd_slow, frozen, red_drv, term_act, cal_def;
  logic dq_en, dqsn_en, rdqs_en, rdqsn_en, rd_iss, rd_start, wr_start, pre_start;
  logic [3:0] rl, wl, wrec;
  logic [1:0] term_sel;
  int cyc = 0;
  int num_errors = 0;
  int checks = 0;
  int t_pulse[5];
  logic [12:0] oe_word[4] = '{13'h1000, 13'h0800, 13'h0c00, 13'h0000};
  logic [3:0] oe_exp[4] = '{4'h0, 4'hf, 4'ha, 4'hc};
  logic [12:0] t_word[3] = '{13'h0004, 13'h0040, 13'h0044};

  sdmr_ctrl_model sdmr_ctrl_model_i (.i_clk(i_clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_bank_sel(bank_sel), .o_addr(addr), .o_odt(odt), .o_bank_open(bank_open));
  sdmr_mode_decode sdmr_mode_decode_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_sel(bank_sel), .i_addr(addr), .i_odt(odt),
    .i_bank_open(bank_open), .o_test_mode(test_mode), .o_dll_enabled(dll_en), .o_dll_reset(dll_rst),
    .o_dll_locked(dll_lock), .o_self_refresh(sref), .o_burst_len8(bl8), .o_read_latency(rl),
    .o_write_latency(wl), .o_write_recovery(wrec), .o_pd_slow_exit(pd_slow), .o_dll_frozen(frozen),
    .o_reduced_drive(red_drv), .o_termination_sel(term_sel), .o_term_active(term_act),
    .o_driver_cal_default(cal_def), .o_dq_out_en(dq_en), .o_dqs_n_en(dqsn_en), .o_rdqs_en(rdqs_en),
    .o_rdqs_n_en(rdqsn_en), .o_read_issue(rd_iss), .o_read_data_start(rd_start),
    .o_write_data_start(wr_start), .o_precharge_start(pre_start));

  always #12.5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end

  // Pulses are stamped mid-cycle with the number of the edge that set them.
  always @(negedge i_clk) begin
    if (rd_iss === 1'b1) t_pulse[0] = cyc;
    if (rd_start === 1'b1) t_pulse[1] = cyc;
    if (wr_start === 1'b1) t_pulse[2] = cyc;
    if (pre_start === 1'b1) t_pulse[3] = cyc;
    if (dll_rst === 1'b1) t_pulse[4] = cyc;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic cyc_wait(input int k);
    repeat (k) @(posedge i_clk);
    #2;
  endtask : cyc_wait

  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // legal codes
  // Only legal latency and recovery codes are programmed here.
  task automatic lat_run(input logic [2:0] al, input logic [2:0] cl, input logic [2:0] wr, input logic b8);
    int n;
    int w;
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_EXTENDED, {7'h00, al, 3'h0});
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, {1'b0, wr, 2'b00, cl, 1'b0, b8 ? 3'h3 : 3'h2});
    t_pulse = '{default: -1};
    sdmr_ctrl_model_i.issue(4'h5, 3'h0, 13'h0000, 1'b1);
    n = cyc;
    w = al + cl - 1;
    cyc_wait(30);
    check("read_issue", t_pulse[0] - n, al + 1);
    check("read_data", t_pulse[1] - n, al + cl);
    sdmr_ctrl_model_i.issue(4'h4, 3'h0, 13'h0400, 1'b1);
    n = cyc;
    cyc_wait(30);
    check("write_data", t_pulse[2] - n, w);
    check("precharge", t_pulse[3] - n, w + (b8 ? 4 : 2) + wr + 1);
    $display("latency test done al %0d cl %0d", al, cl);
  endtask : lat_run

  initial begin
    repeat (4) @(posedge i_clk);
    #2;
    i_rst_n = 1'b1;
    cyc_wait(1);
    check("after_reset", 32'({dll_en, dq_en, dqsn_en, test_mode, dll_rst}), 32'h1c);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, 13'h1753);
    check("op_bits", 32'({bl8, pd_slow, dll_rst, dll_lock, test_mode}), 32'h1c);
    check("op_lat", 32'({rl, wl, wrec}), 32'h544);
    cyc_wait(1);
    check("restart_clear", 32'(dll_rst), 32'h0);
    cyc_wait(205);
    check("locked", 32'(dll_lock), 32'h1);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, 13'h02f2);
    check("test_mode", 32'({test_mode, bl8, rl}), 32'h35);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, 13'h1653);
    check("test_exit", 32'({test_mode, dll_rst}), 32'h0);
    $display("operating test done");
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_EXTENDED, 13'h0393);
    check("ext_bits", 32'({red_drv, cal_def, dll_en, rl, wl}), 32'h676);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_EXTENDED, 13'h0000);
    check("ext_clear", 32'({red_drv, cal_def, dll_en, rl}), 32'h15);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, 13'h1753);
    check("enable_restart", 32'(dll_rst), 32'h1);
    for (int i = 0; i < 4; i++) begin
      sdmr_ctrl_model_i.load(sdmr_pkg::SEL_EXTENDED, oe_word[i]);
      check("out_enables", 32'({dq_en, dqsn_en, rdqs_en, rdqsn_en}), 32'(oe_exp[i]));
    end
    sdmr_ctrl_model_i.issue(4'h0, 3'h2, 13'h1000, 1'b1);
    check("bank_ignored", 32'(dq_en), 32'h1);
    $display("extended test done");
    for (int i = 0; i < 3; i++) begin
      sdmr_ctrl_model_i.load(sdmr_pkg::SEL_EXTENDED, t_word[i]);
      check("term_sel", 32'(term_sel), i + 1);
      cyc_wait(8);
      sdmr_ctrl_model_i.set_pins(1'b1, 1'b1, 1'b0);
      cyc_wait(2);
      check("term_on", 32'(term_act), 32'h1);
      sdmr_ctrl_model_i.set_pins(1'b1, 1'b0, 1'b0);
      cyc_wait(2);
      check("term_off", 32'(term_act), 32'h0);
    end
    $display("termination test done");
    cyc_wait(200);
    check("relock", 32'(dll_lock), 32'h1);
    lat_run(3'h0, 3'h3, 3'h1, 1'b0);
    lat_run(3'h6, 3'h7, 3'h7, 1'b1);
    sdmr_ctrl_model_i.load(sdmr_pkg::SEL_OPERATING, 13'h1232);
    sdmr_ctrl_model_i.set_pins(1'b0, 1'b0, 1'b1);
    cyc_wait(2);
    check("frozen", 32'({frozen, sref, pd_slow}), 32'h5);
    sdmr_ctrl_model_i.set_pins(1'b1, 1'b0, 1'b0);
    cyc_wait(2);
    check("thawed", 32'(frozen), 32'h0);
    sdmr_ctrl_model_i.issue(4'h1, 3'h0, 13'h0000, 1'b0);
    cyc_wait(1);
    check("sref_entry", 32'({sref, dll_en}), 32'h2);
    t_pulse[4] = -1;
    sdmr_ctrl_model_i.set_pins(1'b1, 1'b0, 1'b0);
    cyc_wait(4);
    check("sref_exit", 32'({sref, dll_en, t_pulse[4] > 0}), 32'h3);
    $display("power test done");
    final_report();
  end
endmodule : tb_top
